// ---- hw/asf_pkg.sv ----
/*
  asf_pkg: shared constants for the amplifier stage fault control block.
  Assumes a single 25 MHz clock hclk and AHB-Lite register access.
*/
package asf_pkg;
  localparam int          NUM_CH        = 4;
  localparam int          CLK_MHZ       = 25;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h08;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h0c;
  localparam logic [7:0]  OFS_CONFIG    = 8'h10;
  // ctrl fields
  localparam int          CTRL_SW_EN    = 0;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
  // status fields
  localparam int          ST_SHORT      = 0;
  localparam int          ST_THERM      = 1;
  localparam int          ST_OV         = 2;
  localparam int          ST_UV         = 3;
  localparam int          ST_RUN        = 4;
  localparam int          ST_MODE       = 5;
  localparam int          ST_MODE_W     = 2;
  // irq event bits
  localparam int          IRQ_W         = 5;
  localparam int          EV_SHORT      = 0;
  localparam int          EV_THERM_ON   = 1;
  localparam int          EV_THERM_OFF  = 2;
  localparam int          EV_OV         = 3;
  localparam int          EV_UV         = 4;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 5'h00;
  // thermal warning threshold in degrees C, as a code on the sensor word
  localparam logic [7:0]  THERMAL_WARNING_N_DEGC = 8'd125;
  localparam logic [7:0]  THERM_HYST_DEGC = 8'd10;
  // filter time for protection comparators, ns
  localparam int          FILT_NS       = 200;
  localparam int          FILT_CYC      = (FILT_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {ASF_SE4, ASF_BTL2, ASF_SE2_BTL1} asf_mode_e;
endpackage

// ---- hw/asf_filter.sv ----
/*
  asf_filter: qualifies one raw detector level; output follows the input
  only after it has held steady for CYCLES clocks.
  Assumes the raw input is synchronous to clk.
*/
module asf_filter
  import asf_pkg::*;
#(
  parameter int CYCLES = FILT_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic raw,
  output logic      filt
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_reg;

  // count cycles where raw differs from filt; glitches shorter than the window are dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      filt    <= 1'b0;
    end else if (raw == filt) begin
      cnt_reg <= '0;
    end else if (cnt_reg == CW'(CYCLES - 1)) begin
      cnt_reg <= '0;
      filt    <= raw;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule

// ---- hw/asf_halfbridge.sv ----
/*
  asf_halfbridge: gate command for one half-bridge output.
  Assumes pos/neg inputs synchronous to clk; drive low means outputs idle.
*/
module asf_halfbridge (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic allow,
  input  wire logic invert,
  input  wire logic pos_in,
  input  wire logic neg_in,
  output logic      hs_on,
  output logic      ls_on,
  output logic      pair_err
);
  wire logic valid_pair = pos_in ^ neg_in;
  wire logic level      = invert ? neg_in : pos_in;

  // both fets off when disabled or the pair is not complementary
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_on    <= 1'b0;
      ls_on    <= 1'b0;
      pair_err <= 1'b0;
    end else begin
      hs_on    <= allow & valid_pair & level;
      ls_on    <= allow & valid_pair & ~level;
      pair_err <= ~valid_pair;
    end
  end
endmodule

// ---- hw/asf_top.sv ----
/*
  asf_top: control and fault reporting of a four-channel class-D stage.
  Holds the short-circuit latch, the thermal warning with hysteresis, the
  supply fault gating, the output layout select, four half-bridge gate
  command slices and a small register file with a level interrupt.
  Read accesses take one wait state; writes complete with none.
  Assumes one 25 MHz clock, AHB-Lite single-word access, and analog
  detectors (short, over/under voltage, die temperature) synchronous to hclk.
  Assumes the controller keeps each pwm pair complementary; a broken pair
  only idles its own half-bridge and is reported, it is not latched.
  Assumes the detector levels already carry their own analog thresholds;
  only the die temperature arrives as a number and is compared here.
*/
module asf_top
  import asf_pkg::*;
#(
  parameter int NCH = NUM_CH
) (
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic [31:0]    hwdata,
  input  wire logic           hready,
  output logic [31:0]         hrdata,
  output logic                hreadyout,
  output logic                hresp,
  input  wire logic           chan_a_pos_pwm_in,
  input  wire logic           chan_a_neg_pwm_in,
  input  wire logic           chan_b_pos_pwm_in,
  input  wire logic           chan_b_neg_pwm_in,
  input  wire logic           chan_c_pos_pwm_in,
  input  wire logic           chan_c_neg_pwm_in,
  input  wire logic           chan_d_pos_pwm_in,
  input  wire logic           chan_d_neg_pwm_in,
  input  wire logic           enable_in,
  input  wire logic           output_mode_strap,
  input  wire logic           bridge_pair_cd,
  input  wire logic [NCH-1:0] short_detect,
  input  wire logic           overvolt_detect,
  input  wire logic           undervolt_detect,
  input  wire logic [7:0]     die_temp_degc,
  output logic [NCH-1:0]      hs_gate_on,
  output logic [NCH-1:0]      ls_gate_on,
  output logic                short_fault_n,
  output logic                thermal_warning_n,
  output logic                irq
);
  // pwm pairs gathered by channel index a..d
  wire logic [NCH-1:0] pos_in = {chan_d_pos_pwm_in, chan_c_pos_pwm_in,
                                 chan_b_pos_pwm_in, chan_a_pos_pwm_in};
  wire logic [NCH-1:0] neg_in = {chan_d_neg_pwm_in, chan_c_neg_pwm_in,
                                 chan_b_neg_pwm_in, chan_a_neg_pwm_in};

  logic                 short_latch_reg;
  logic                 therm_reg;
  logic                 sw_en_reg;
  logic [IRQ_W-1:0]     irq_stat_reg;
  logic [IRQ_W-1:0]     irq_mask_reg;
  logic [IRQ_W-1:0]     irq_stat_next;
  logic                 enable_q_reg;
  asf_mode_e            mode_reg;
  logic                 ph_wr_reg;
  logic                 ph_rd_reg;
  logic [7:0]           ph_addr_reg;
  logic                 ov_q_reg;
  logic                 uv_q_reg;
  logic [NCH-1:0]       pair_err;
  logic [NCH-1:0]       short_f;
  logic                 ov_f;
  logic                 uv_f;

  // the enable pin acts as a synchronous reset of the short latch and reloads mode_reg from the strap; thermal, supply and irq status are not reset by it
  wire logic stage_rst_n = enable_in;

  // detector qualification; one filter per short input plus two supplies.
  // the filter costs a few cycles of reaction time but keeps switching
  // spikes on the detector lines from tripping the latch
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_sc
      asf_filter u_sc (
        .clk   (hclk),
        .rst_n (hresetn),
        .raw   (short_detect[g]),
        .filt  (short_f[g])
      );
    end
  endgenerate

  asf_filter u_ov (
    .clk   (hclk),
    .rst_n (hresetn),
    .raw   (overvolt_detect),
    .filt  (ov_f)
  );

  asf_filter u_uv (
    .clk   (hclk),
    .rst_n (hresetn),
    .raw   (undervolt_detect),
    .filt  (uv_f)
  );

  // only output shorts feed the latch; thermal is kept off this path
  wire logic short_hit = |short_f;

  // short latch: set by a short, cleared only by the enable pin going low.
  // clear has priority, so a short that persists through reset re-latches
  // only once the enable pin is high again
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      short_latch_reg <= 1'b0;
    end else if (!stage_rst_n) begin
      short_latch_reg <= 1'b0;
    end else if (short_hit) begin
      short_latch_reg <= 1'b1;
    end
  end

  // thermal warning with hysteresis so it does not chatter at threshold;
  // between the two limits the flag keeps whatever it last held
  localparam logic [7:0] THERM_REL_DEGC = THERMAL_WARNING_N_DEGC - THERM_HYST_DEGC;
  wire logic therm_on  = die_temp_degc >= THERMAL_WARNING_N_DEGC;
  wire logic therm_off = die_temp_degc < THERM_REL_DEGC;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      therm_reg <= 1'b0;
    end else if (therm_on) begin
      therm_reg <= 1'b1;
    end else if (therm_off) begin
      therm_reg <= 1'b0;
    end
  end

  // strap selects layout; bridge_pair_cd picks mixed vs all single-ended.
  // a strap change while running is ignored until the next enable low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg <= ASF_BTL2;
    end else if (!stage_rst_n) begin
      // only sampled while held in reset, so layout cannot change mid-play
      if (!output_mode_strap) begin
        mode_reg <= ASF_BTL2;
      end else if (bridge_pair_cd) begin
        mode_reg <= ASF_SE2_BTL1;
      end else begin
        mode_reg <= ASF_SE4;
      end
    end
  end

  // second half of each bridge runs inverted so the load sees the difference
  wire logic [NCH-1:0] invert_mask =
    (mode_reg == ASF_BTL2)     ? 4'b1010 :
    (mode_reg == ASF_SE2_BTL1) ? 4'b1000 : 4'b0000;

  // supply faults stop switching but do not latch, unlike a short;
  // the live short term idles the gates in the cycle before the latch
  // sets, and software can pause switching through the ctrl enable bit
  wire logic allow_sw = stage_rst_n & ~short_latch_reg & ~short_hit
                        & ~ov_f & ~uv_f & ~therm_on & sw_en_reg;

  generate
    for (g = 0; g < NCH; g++) begin : g_hb
      asf_halfbridge u_hb (
        .clk      (hclk),
        .rst_n    (hresetn),
        .allow    (allow_sw),
        .invert   (invert_mask[g]),
        .pos_in   (pos_in[g]),
        .neg_in   (neg_in[g]),
        .hs_on    (hs_gate_on[g]),
        .ls_on    (ls_gate_on[g]),
        .pair_err (pair_err[g])
      );
    end
  endgenerate

  // pin outputs registered, active low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      short_fault_n     <= 1'b1;
      thermal_warning_n <= 1'b1;
    end else begin
      short_fault_n     <= ~(short_latch_reg | (stage_rst_n & short_hit));
      thermal_warning_n <= ~therm_reg;
    end
  end

  // delayed copies for status and for the supply event edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_q_reg <= 1'b0;
      ov_q_reg     <= 1'b0;
      uv_q_reg     <= 1'b0;
    end else begin
      enable_q_reg <= stage_rst_n;
      ov_q_reg     <= ov_f;
      uv_q_reg     <= uv_f;
    end
  end

  // event edges for the interrupt status; each is one cycle wide so a
  // level that stays up does not refill a bit that software has cleared.
  // the short event is muted while the latch is already set or while the
  // stage is held in reset, so only the first hit of a fault is counted
  wire logic [IRQ_W-1:0] ev;
  assign ev[EV_SHORT]     = short_hit & ~short_latch_reg & stage_rst_n;
  assign ev[EV_THERM_ON]  = therm_on & ~therm_reg;
  assign ev[EV_THERM_OFF] = therm_off & therm_reg;
  assign ev[EV_OV]        = ov_f & ~ov_q_reg;
  assign ev[EV_UV]        = uv_f & ~uv_q_reg;

  // offset match, shared by the write strobes and the read mux
  function automatic logic addr_is(input logic [7:0] a,
                                   input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // ahb address phase decode; nonseq and seq both count as a transfer
  wire logic       ahb_go    = hsel & hready & htrans[1];

  // one select per register, taken from the registered data-phase address
  wire logic       sel_ctrl  = addr_is(ph_addr_reg, OFS_CTRL);
  wire logic       sel_stat  = addr_is(ph_addr_reg, OFS_STATUS);
  wire logic       sel_istat = addr_is(ph_addr_reg, OFS_IRQ_STAT);
  wire logic       sel_imask = addr_is(ph_addr_reg, OFS_IRQ_MASK);
  wire logic       sel_cfg   = addr_is(ph_addr_reg, OFS_CONFIG);

  // write strobes land at the edge that ends the data phase, with hwdata
  wire logic       wr_ctrl   = ph_wr_reg & sel_ctrl;
  wire logic       wr_stat   = ph_wr_reg & sel_istat;
  wire logic       wr_mask   = ph_wr_reg & sel_imask;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_reg   <= 1'b0;
      ph_rd_reg   <= 1'b0;
      ph_addr_reg <= 8'h00;
    end else begin
      ph_wr_reg   <= ahb_go & hwrite;
      ph_rd_reg   <= ahb_go & ~hwrite;
      ph_addr_reg <= haddr[7:0];
    end
  end

  // write-one-to-clear; a new event in the same cycle wins over the clear
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (wr_stat) begin
      irq_stat_next = irq_stat_next & ~hwdata[IRQ_W-1:0];
    end
    irq_stat_next = irq_stat_next | ev;
  end

  // sticky status and the interrupt pin, which updates at the same edge as the status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_reg <= '0;
      irq          <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq          <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // mask register, written as a whole
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_reg <= IRQ_MASK_RESET;
    end else if (wr_mask) begin
      irq_mask_reg <= hwdata[IRQ_W-1:0];
    end
  end

  // control register; only the switching enable is implemented
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_en_reg <= CTRL_RESET[CTRL_SW_EN];
    end else if (wr_ctrl) begin
      sw_en_reg <= hwdata[CTRL_SW_EN];
    end
  end

  // live status word; bits follow the status field positions
  wire logic [31:0] status_word =
    32'(({mode_reg, enable_q_reg, uv_f, ov_f, therm_reg, short_latch_reg}));

  // the narrow registers, zero-extended to the bus width
  wire logic [31:0] ctrl_word  = {31'h0, sw_en_reg};
  wire logic [31:0] istat_word = {27'h0, irq_stat_reg};
  wire logic [31:0] imask_word = {27'h0, irq_mask_reg};
  wire logic [31:0] cfg_word   = {28'h0, pair_err};

  // read select; unmapped offsets fall through to zero
  wire logic [31:0] rd_mux =
    sel_ctrl  ? ctrl_word :
    sel_stat  ? status_word :
    sel_istat ? istat_word :
    sel_imask ? imask_word :
    sel_cfg   ? cfg_word : 32'h0;

  // one wait state on reads, none on writes; unmapped reads return zero
  // with okay. the read word is taken from the registered address so the
  // mux sits in the data phase and does not lengthen the address path
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hrdata    <= (ahb_go & ~hwrite) ? 32'h0 : hrdata;
      hreadyout <= ~(ahb_go & ~hwrite);
      hresp     <= 1'b0;
      if (ph_rd_reg) begin
        hrdata <= rd_mux;
      end
    end
  end
endmodule

// ---- bench/asf_top_props.sv ----
/*
  asf_top_props: port-level checks of asf_top.
  Assumes it is bound into asf_top and sees its ports only.
*/
module asf_top_props
  import asf_pkg::*;
#(
  parameter int NCH = NUM_CH
) (
  input wire logic           hclk,
  input wire logic           hresetn,
  input wire logic           hsel,
  input wire logic [1:0]     htrans,
  input wire logic           hwrite,
  input wire logic           hready,
  input wire logic           hreadyout,
  input wire logic           enable_in,
  input wire logic [NCH-1:0] short_detect,
  input wire logic [7:0]     die_temp_degc,
  input wire logic [NCH-1:0] hs_gate_on,
  input wire logic [NCH-1:0] ls_gate_on,
  input wire logic           short_fault_n,
  input wire logic           thermal_warning_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // one domain, so clock and reset are given once
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // latch and release of the short fault
  a_short_held: assert property (enable_in && $past(enable_in) && !short_fault_n |=> !short_fault_n)
    else $error("short fault released while enabled");
  a_short_clear: assert property (!enable_in |-> ##2 short_fault_n)
    else $error("short fault kept through enable low");
  a_short_set: assert property ((enable_in && short_detect != '0)[*8] |=> !short_fault_n)
    else $error("short not reported");
  a_short_only: assert property ((short_fault_n && short_detect == '0)[*8] |=> short_fault_n)
    else $error("fault pin low without short");
  // no switching in reset or after a short
  a_gate_reset: assert property (!enable_in |=> hs_gate_on == '0 && ls_gate_on == '0)
    else $error("switching while held in reset");
  a_gate_fault: assert property (!short_fault_n |=> hs_gate_on == '0 && ls_gate_on == '0)
    else $error("switching after short");
  // thermal warning follows temperature, hysteresis below the threshold
  a_therm_set: assert property ((die_temp_degc >= THERMAL_WARNING_N_DEGC)[*8] |=> !thermal_warning_n)
    else $error("thermal warning missing");
  a_therm_clear: assert property ((die_temp_degc < THERMAL_WARNING_N_DEGC - THERM_HYST_DEGC)[*8] |=> thermal_warning_n)
    else $error("thermal warning stuck");
  // reads carry one wait state
  a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
endmodule

bind asf_top asf_top_props #(.NCH(NCH)) i_props (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .enable_in, .short_detect, .die_temp_degc, .hs_gate_on, .ls_gate_on, .short_fault_n,
  .thermal_warning_n);

// ---- bench/asf_pwm_model.sv ----
/*
  asf_pwm_model: PWM processor driving the four input pairs.
  Assumes hclk as its timebase; break_pair is commanded by the bench.
*/
module asf_pwm_model (
  input  wire logic  hclk,
  input  wire logic  hresetn,
  input  wire logic  break_pair,
  output logic [3:0] pos,
  output logic [3:0] neg
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_reg;

  // counter bits give each channel its own toggle rate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt_reg <= 4'h0;
    else cnt_reg <= cnt_reg + 4'h1;
  end

  // negative side is the complement; break_pair spoils channel a only
  assign pos = cnt_reg;
  assign neg = ~cnt_reg ^ {3'h0, break_pair};
endmodule

// ---- bench/asf_top_tb.sv ----
/*
  asf_top_tb: self-checking bench of asf_top.
  Assumes the pwm model as controller and one 25 MHz clock.
*/
`define CHK(a, e, m) begin \
  checks_done++; \
  if ((a) !== (e)) begin \
    miscompares++; \
    $display("wrong value t=%0t %s", $time, m); \
  end \
end

module asf_top_tb;
  import asf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic        enable_in, output_mode_strap, bridge_pair_cd, break_pair;
  logic        overvolt_detect, undervolt_detect, short_fault_n, thermal_warning_n;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [3:0]  short_detect, hs_gate_on, ls_gate_on, pos, neg;
  logic [7:0]  die_temp_degc;
  int          miscompares, checks_done, cyc, i;

  asf_pwm_model i_pwm (.hclk, .hresetn, .break_pair, .pos, .neg);
  asf_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .chan_a_pos_pwm_in(pos[0]), .chan_a_neg_pwm_in(neg[0]),
    .chan_b_pos_pwm_in(pos[1]), .chan_b_neg_pwm_in(neg[1]), .chan_c_pos_pwm_in(pos[2]),
    .chan_c_neg_pwm_in(neg[2]), .chan_d_pos_pwm_in(pos[3]), .chan_d_neg_pwm_in(neg[3]), .enable_in,
    .output_mode_strap, .bridge_pair_cd, .short_detect, .overvolt_detect, .undervolt_detect,
    .die_temp_degc, .hs_gate_on, .ls_gate_on, .short_fault_n, .thermal_warning_n, .irq);

  // 40 ns clock
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // hang guard, far above the expected run
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      $display("wrong value t=%0t timeout", $time);
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // one single transfer; waits on hready, read data taken at the closing edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic t_regs();
    xfer(1'b0, OFS_CTRL, 32'h0);
    `CHK(rd, CTRL_RESET, "ctrl reset")
    xfer(1'b0, OFS_IRQ_MASK, 32'h0);
    `CHK(rd[IRQ_W-1:0], IRQ_MASK_RESET, "mask reset")
    xfer(1'b1, 8'h40, 32'hffff_ffff);
    xfer(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h0, "unmapped read")
    `CHK(hresp, 1'b0, "response not okay")
    $display("test regs done");
  endtask

  // strap sampled while held in reset; table indexed by mode code
  task automatic t_modes();
    logic [1:0] sb [3];
    sb = '{2'b10, 2'b00, 2'b11};
    for (i = 0; i < 3; i++) begin
      @(posedge hclk);
      enable_in <= 1'b0;
      {output_mode_strap, bridge_pair_cd} <= sb[i];
      repeat (3) @(posedge hclk);
      enable_in <= 1'b1;
      xfer(1'b0, OFS_STATUS, 32'h0);
      `CHK(rd[ST_MODE +: ST_MODE_W], 2'(i), "mode")
      `CHK(|(hs_gate_on | ls_gate_on), 1'b1, "not switching")
    end
    $display("test modes done");
  endtask

  task automatic t_short();
    xfer(1'b1, OFS_IRQ_MASK, 32'h1);
    short_detect <= 4'h2;
    for (i = 0; i < 20 && short_fault_n !== 1'b0; i++) @(posedge hclk);
    `CHK(short_fault_n, 1'b0, "short not seen")
    short_detect <= 4'h0;
    repeat (20) @(posedge hclk);
    `CHK(short_fault_n, 1'b0, "latch lost")
    `CHK(hs_gate_on | ls_gate_on, 4'h0, "switching after short")
    `CHK(irq, 1'b1, "irq missing")
    xfer(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[ST_SHORT], 1'b1, "short status")
    xfer(1'b1, OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge hclk);
    `CHK(irq, 1'b0, "irq stuck")
    enable_in <= 1'b0;
    repeat (3) @(posedge hclk);
    `CHK(short_fault_n, 1'b1, "latch not cleared")
    enable_in <= 1'b1;
    $display("test short done");
  endtask

  task automatic t_therm();
    die_temp_degc <= THERMAL_WARNING_N_DEGC - 8'd1;
    repeat (20) @(posedge hclk);
    `CHK(thermal_warning_n, 1'b1, "early warning")
    die_temp_degc <= THERMAL_WARNING_N_DEGC;
    repeat (20) @(posedge hclk);
    `CHK(thermal_warning_n, 1'b0, "no warning")
    `CHK(short_fault_n, 1'b1, "thermal on fault pin")
    `CHK(irq, 1'b0, "masked irq raised")
    die_temp_degc <= 8'd40;
    repeat (20) @(posedge hclk);
    `CHK(thermal_warning_n, 1'b1, "warning stuck")
    xfer(1'b0, OFS_IRQ_STAT, 32'h0);
    `CHK(rd[EV_THERM_OFF:EV_THERM_ON], 2'h3, "thermal events")
    $display("test thermal done");
  endtask

  task automatic t_supply();
    overvolt_detect <= 1'b1;
    repeat (20) @(posedge hclk);
    `CHK(hs_gate_on | ls_gate_on, 4'h0, "switching in overvoltage")
    xfer(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[ST_UV:ST_OV], 2'h1, "ov status")
    overvolt_detect <= 1'b0;
    undervolt_detect <= 1'b1;
    repeat (20) @(posedge hclk);
    xfer(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[ST_UV:ST_OV], 2'h2, "uv status")
    `CHK(short_fault_n, 1'b1, "supply on fault pin")
    xfer(1'b0, OFS_IRQ_STAT, 32'h0);
    `CHK(rd[EV_UV:EV_OV], 2'h3, "supply events")
    undervolt_detect <= 1'b0;
    break_pair <= 1'b1;
    repeat (10) @(posedge hclk);
    xfer(1'b0, OFS_CONFIG, 32'h0);
    `CHK(rd[0], 1'b1, "pair error missing")
    break_pair <= 1'b0;
    $display("test supply done");
  endtask

  // reset for ten cycles, then the tests in order
  initial begin
    {hsel, hwrite, enable_in, output_mode_strap, bridge_pair_cd, break_pair} = 6'h0;
    {overvolt_detect, undervolt_detect, hresetn} = 3'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    short_detect = 4'h0;
    die_temp_degc = 8'd40;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_modes();
    t_short();
    t_therm();
    t_supply();
    close_out();
  end
endmodule
